// File: rtl/dbg_trace.sv
// Trigger and breakpoint controller with three comparators and a trace FIFO.
// Assumes the core bus, change-of-flow strobe and Avalon master share sys_clk.
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`include "dbg_trace_map.svh"
module dbg_trace
   import dbg_trace_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire core_bus_s   core_bus,
   input  wire cof_s        change_of_flow,
   output logic             brk_force,
   output logic             brk_tag,
   output logic             trace_armed
);
   // =====================================================================
   // State record.
   typedef struct packed {
      ctrl_s          ctrl;
      cmp_cfg_s [2:0] cmp;
      run_e           run;
      logic           a_seen;
      logic           af;
      logic           bf;
      logic           cf;
      logic [3:0]     count;
      logic           brk_force;
      logic           brk_tag;
      logic           bus_wait;
      logic           trace_on;
      logic [31:0]    rdata;
   } dbg_st_s;

   dbg_st_s     st_ff;
   dbg_st_s     nxt_st;
   logic [2:0]  mtch;
   logic        full_mode;
   logic        full_write;
   logic        ev_mode;
   logic        armed;
   logic        trig;
   logic        brk_now;
   logic        push;
   logic [15:0] push_data;
   logic        fifo_pop;
   logic        fifo_clr;
   logic [15:0] fifo_rd;
   logic        wr_acc;
   logic        rd_acc;
   logic        arm_evt;
   logic        loop1_dup;
   logic [31:0] rd_mux;
   ctrl_s       wctrl;
   cmp_cfg_s    wcmp;

   // =====================================================================
   // Comparators.
   // Full modes put comparator B on the data bus and share A's direction.
   assign full_mode  = (st_ff.ctrl.mode == `MODE_A_AND_B) || (st_ff.ctrl.mode == `MODE_A_NOT_B);
   assign full_write = st_ff.cmp[0].dir_en && !st_ff.cmp[0].dir_sel;
   assign ev_mode    = (st_ff.ctrl.mode == `MODE_EV_B) || (st_ff.ctrl.mode == `MODE_A_THEN_EV);
   assign armed      = st_ff.ctrl.enable && st_ff.ctrl.arm;

   // comparator array instances
   // Comparator B is the only one switched to the data bus.
   for (genvar i = 0; i < 3; i++) begin : g_cmp
      cmp_unit u_cmp (
         .bus        (core_bus),
         .cfg        (st_ff.cmp[i]),
         .full_mode  (full_mode && i < 2),
         .full_write (full_write),
         .data_mode  (full_mode && i == 1),
         .match      (mtch[i])
      );
   end

   trace_fifo u_fifo (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .ce        (ce),
      .clear     (fifo_clr),
      .push      (push),
      .push_data (push_data),
      .pop       (fifo_pop),
      .rd_data   (fifo_rd)
   );

   // =====================================================================
   // Trigger decode.
   // A and B feed the trigger; C stays out of it.
   always_comb begin
      case (st_ff.ctrl.mode)
         `MODE_A_ONLY:    trig = mtch[0];
         `MODE_A_OR_B:    trig = mtch[0] || mtch[1];
         `MODE_A_THEN_B:  trig = st_ff.a_seen && mtch[1];
         `MODE_EV_B:      trig = mtch[1];
         `MODE_A_THEN_EV: trig = mtch[0];
         `MODE_A_AND_B:   trig = mtch[0] && mtch[1];
         `MODE_A_NOT_B:   trig = mtch[0] && !mtch[1];
         default:         trig = mtch[0];
      endcase
   end

   assign loop1_dup = st_ff.ctrl.loop1 && (change_of_flow.addr == st_ff.cmp[2].addr);

   // Avalon handshake terms; a write lands on the edge that sees waitrequest low.
   assign wr_acc  = avs_write && !st_ff.bus_wait;
   assign rd_acc  = avs_read && !st_ff.bus_wait;
   assign wctrl   = {avs_writedata[`CTRL_ENABLE], avs_writedata[`CTRL_ARM],
                     avs_writedata[`CTRL_BREAK_ENABLE], avs_writedata[`CTRL_TAG],
                     st_ff.ctrl.mode, st_ff.ctrl.begin_sel, st_ff.ctrl.loop1};
   // Comparator words keep the address in the low half, direction bits above it.
   assign wcmp    = {avs_writedata[15:0], avs_writedata[`CMP_DIR_EN],
                     avs_writedata[`CMP_DIR_SEL]};
   assign arm_evt = wr_acc && (avs_address == `OFS_CTRL) && wctrl.enable && wctrl.arm
                    && !armed;

   // Register read mux; unmapped words read zero.
   always_comb begin
      case (avs_address)
         `OFS_CTRL:   rd_mux = {28'h0, st_ff.ctrl.tag, st_ff.ctrl.break_enable,
                                st_ff.ctrl.arm, st_ff.ctrl.enable};
         `OFS_TRIG:   rd_mux = {26'h0, st_ff.ctrl.loop1, st_ff.ctrl.begin_sel, st_ff.ctrl.mode};
         `OFS_STATUS: rd_mux = {28'h0, st_ff.af, st_ff.bf, st_ff.cf, armed};
         `OFS_COUNT:  rd_mux = {28'h0, st_ff.count};
         `OFS_CMP_A:  rd_mux = {14'h0, st_ff.cmp[0].dir_sel, st_ff.cmp[0].dir_en, st_ff.cmp[0].addr};
         `OFS_CMP_B:  rd_mux = {14'h0, st_ff.cmp[1].dir_sel, st_ff.cmp[1].dir_en, st_ff.cmp[1].addr};
         `OFS_CMP_C:  rd_mux = {14'h0, st_ff.cmp[2].dir_sel, st_ff.cmp[2].dir_en, st_ff.cmp[2].addr};
         `OFS_FIFO:   rd_mux = {16'h0, fifo_rd};
         default:     rd_mux = `RST_WORD;
      endcase
   end

   // =====================================================================
   // Next state: bus slave, run control, capture and breakpoints.
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.brk_force = 1'b0;
      nxt_st.brk_tag   = 1'b0;
      push       = 1'b0;
      push_data  = 16'h0000;
      brk_now    = 1'b0;
      fifo_clr   = arm_evt;
      fifo_pop   = rd_acc && (avs_address == `OFS_FIFO);
      // One wait cycle per access keeps read data registered.
      nxt_st.bus_wait = !(st_ff.bus_wait && (avs_read || avs_write));
      if (st_ff.bus_wait && avs_read) begin
         nxt_st.rdata = rd_mux;
      end
      if (armed) begin
         nxt_st.a_seen = st_ff.a_seen || mtch[0];
         if (full_mode) begin
            nxt_st.af = st_ff.af || trig;
            nxt_st.bf = st_ff.bf || trig;
         end else begin
            nxt_st.af = st_ff.af || mtch[0];
            nxt_st.bf = st_ff.bf || (mtch[1] && (st_ff.ctrl.mode != `MODE_A_ONLY));
         end
         nxt_st.cf = st_ff.cf || (mtch[2] && !st_ff.ctrl.loop1);
      end
      // Capture source: data bus at B matches in event modes, else change of flow.
      push_data = ev_mode ? {8'h00, core_bus.rd ? core_bus.rdata : core_bus.wdata} : change_of_flow.addr;
      case (st_ff.run)
         RUN_END: begin
            push = (change_of_flow.valid && !loop1_dup) && armed;
            if (trig && armed) begin
               brk_now         = 1'b1;
               push            = 1'b0;
               nxt_st.ctrl.arm = 1'b0;
               nxt_st.run      = RUN_IDLE;
            end
         end
         RUN_WAIT: begin
            if (trig && armed) begin
               nxt_st.run = RUN_FILL;
            end
         end
         RUN_FILL: begin
            push = armed && (ev_mode ? mtch[1] : (change_of_flow.valid && !loop1_dup));
            if (push && st_ff.count == `COUNT_FULL - 4'h1) begin
               brk_now         = 1'b1;
               nxt_st.ctrl.arm = 1'b0;
               nxt_st.run      = RUN_IDLE;
            end
         end
         default: begin
            push = 1'b0;
         end
      endcase
      if (push && st_ff.ctrl.loop1 && !ev_mode) begin
         nxt_st.cmp[2].addr = change_of_flow.addr;
      end
      if (push && st_ff.count != `COUNT_FULL) begin
         nxt_st.count = st_ff.count + 4'h1;
      end
      if (st_ff.ctrl.enable && mtch[2] && !st_ff.ctrl.loop1) begin
         brk_now = 1'b1;
      end
      if (brk_now && st_ff.ctrl.enable && st_ff.ctrl.break_enable) begin
         nxt_st.brk_force = !st_ff.ctrl.tag;
         nxt_st.brk_tag   = st_ff.ctrl.tag;
      end
      // Register writes from the host.
      if (wr_acc) begin
         case (avs_address)
            `OFS_CTRL: begin
               nxt_st.ctrl.enable = wctrl.enable;
               nxt_st.ctrl.arm    = wctrl.arm;
               nxt_st.ctrl.break_enable  = wctrl.break_enable;
               nxt_st.ctrl.tag    = wctrl.tag;
            end
            `OFS_TRIG: begin
               nxt_st.ctrl.mode      = avs_writedata[3:0];
               nxt_st.ctrl.begin_sel = avs_writedata[`TRIG_BEGIN];
               nxt_st.ctrl.loop1     = avs_writedata[`TRIG_LOOP1];
            end
            `OFS_CMP_A: nxt_st.cmp[0] = wcmp;
            `OFS_CMP_B: nxt_st.cmp[1] = wcmp;
            `OFS_CMP_C: nxt_st.cmp[2] = wcmp;
            default: begin
               nxt_st.rdata = nxt_st.rdata;
            end
         endcase
      end
      // Arming starts a fresh run with cleared flags and count.
      if (arm_evt) begin
         nxt_st.count  = 4'h0;
         nxt_st.af     = 1'b0;
         nxt_st.bf     = 1'b0;
         nxt_st.cf     = 1'b0;
         nxt_st.a_seen = 1'b0;
         if (st_ff.ctrl.mode == `MODE_EV_B) begin
            nxt_st.run = RUN_FILL;
         end else if (st_ff.ctrl.begin_sel || ev_mode) begin
            nxt_st.run = RUN_WAIT;
         end else begin
            nxt_st.run = RUN_END;
         end
         if (st_ff.ctrl.loop1) begin
            nxt_st.cmp[2].addr = 16'h0000;
         end
      end
      if (!nxt_st.ctrl.enable) begin
         nxt_st.run = RUN_IDLE;
      end
      // The armed output is registered beside the run state so it leaves on a flop.
      nxt_st.trace_on = nxt_st.run != RUN_IDLE;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff          <= '0;
         st_ff.bus_wait <= 1'b1;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata    = st_ff.rdata;
   assign avs_waitrequest = st_ff.bus_wait;
   assign brk_force       = st_ff.brk_force;
   assign brk_tag         = st_ff.brk_tag;
   assign trace_armed     = st_ff.trace_on;

   // =====================================================================
   // Assertions.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   no_store_off_a: assert property (!st_ff.ctrl.enable |-> !push)
      else $error("FIFO stored while the block was disabled.");
   idle_when_off_a: assert property ((ce && !st_ff.ctrl.enable && !arm_evt)
      |=> st_ff.run == RUN_IDLE)
      else $error("Run state left idle while disabled.");
   cmp_a_hit_a: assert property ((core_bus.valid && !full_mode && !st_ff.cmp[0].dir_en
      && core_bus.addr == st_ff.cmp[0].addr) |-> mtch[0])
      else $error("Comparator A missed an equal address.");
   cmp_b_data_a: assert property ((full_mode && mtch[1]) |->
      (full_write ? core_bus.wdata : core_bus.rdata) == st_ff.cmp[1].addr[7:0])
      else $error("Comparator B matched a different data byte.");
   full_dir_a: assert property ((full_mode && mtch[1]) |-> core_bus.rd == !full_write)
      else $error("Full-mode compare took the wrong direction.");
   loop1_clear_a: assert property ((ce && arm_evt && st_ff.ctrl.loop1)
      |=> st_ff.cmp[2].addr == 16'h0000)
      else $error("Comparator C not cleared on loop1 arming.");
   dup_block_a: assert property ((st_ff.ctrl.loop1 && !ev_mode && change_of_flow.valid && loop1_dup)
      |-> !push)
      else $error("Duplicate change of flow was captured.");
   cof_load_a: assert property ((ce && push && st_ff.ctrl.loop1 && !ev_mode && !wr_acc)
      |=> st_ff.cmp[2].addr == $past(change_of_flow.addr))
      else $error("Captured address not loaded into comparator C.");
   brk_gate_a: assert property ((ce && !st_ff.ctrl.break_enable) |=> !brk_force && !brk_tag)
      else $error("Break requested with break enable clear.");
   end_brk_a: assert property ((ce && armed && st_ff.run == RUN_END && trig
      && st_ff.ctrl.break_enable) |=> (brk_force || brk_tag) ##1 !brk_force && !brk_tag)
      else $error("End run break missing or longer than one cycle.");
   count_step_a: assert property ((ce && push && st_ff.count != `COUNT_FULL && !arm_evt)
      |=> st_ff.count == $past(st_ff.count) + 4'h1)
      else $error("Valid count did not step on capture.");
   count_cap_a: assert property (st_ff.count <= `COUNT_FULL)
      else $error("Valid count passed eight.");
   kind_sel_a: assert property ((ce && brk_now && st_ff.ctrl.enable && st_ff.ctrl.break_enable
      && st_ff.ctrl.tag) |=> brk_tag && !brk_force)
      else $error("Tag break not issued as tag type.");
   force_kind_a: assert property ((ce && brk_now && st_ff.ctrl.enable
      && st_ff.ctrl.break_enable && !st_ff.ctrl.tag) |=> brk_force && !brk_tag)
      else $error("Force break not issued as force type.");
   fill_brk_a: assert property ((ce && st_ff.run == RUN_FILL && push
      && st_ff.ctrl.break_enable && st_ff.count == `COUNT_FULL - 4'h1) |=> brk_force || brk_tag)
      else $error("Begin run did not break at the eighth word.");
   loop1_c_quiet_a: assert property ((st_ff.ctrl.loop1 && st_ff.run == RUN_IDLE)
      |-> !brk_now)
      else $error("Comparator C raised a break in loop1 mode.");
   b_dir_ignore_a: assert property ((core_bus.valid && full_mode && !full_write
      && core_bus.rd && core_bus.rdata == st_ff.cmp[1].addr[7:0]) |-> mtch[1])
      else $error("Comparator B data compare held back by its own direction bits.");

   end_run_c: cover property (st_ff.run == RUN_END ##[1:50] brk_force);
   begin_fill_c: cover property (st_ff.run == RUN_FILL ##[1:200] st_ff.count == `COUNT_FULL);
   dup_skip_c: cover property (st_ff.run == RUN_END && change_of_flow.valid && loop1_dup);
   tag_brk_c: cover property (brk_tag);
   full_trig_c: cover property (armed && full_mode && trig);
endmodule

// File: rtl/dbg_trace_map.svh
// Offsets, field positions, reset values and counts of the debug trigger block.
// Assumes byte addressing on a 32-bit Avalon-MM slave, one register per aligned word.
// How it works
// - Module enable clear blocks arming, triggering and FIFO storage.
// - Comparator A matches when core address equals its stored address.
// - Comparator B compares address, or data against its low byte in full modes.
// - Comparator C compares address; all three matches go to the controller.
// - Full modes take direction from comparator A bits; write only for 1 and 0.
// - Comparator B direction bits are ignored in full modes.
// - Outside loop1 comparator C is only an extra breakpoint, never a trigger.
// - In loop1 comparator C holds the latest captured change-of-flow address.
// - Arming in loop1 clears comparator C value registers.
// - In loop1 a change of flow equal to comparator C is not captured.
// - In loop1 a differing change of flow is captured and loaded into C.
// - End-of-run CPU break is requested only with break enable set.
// - Begin runs request the break once the FIFO holds eight words.
// - End runs request the break together with the trigger.
// - Kind bit 0 requests a force break at the next instruction boundary.
// - Kind bit 1 inserts a tag into the instruction queue instead.
// - Valid count clears on arming, counts captures, saturates at eight.
// - Begin runs store from the trigger, or from arming in MODE_EV_B, until eight locations are filled.
// - End runs store until the trigger, dropping the oldest beyond eight.
`ifndef DBG_TRACE_MAP_SVH
`define DBG_TRACE_MAP_SVH
// =====================================================================
// Register offsets.
`define OFS_CTRL    5'h00
`define OFS_TRIG    5'h04
`define OFS_STATUS  5'h08
`define OFS_COUNT   5'h0C
`define OFS_CMP_A   5'h10
`define OFS_CMP_B   5'h14
`define OFS_CMP_C   5'h18
`define OFS_FIFO    5'h1C
// =====================================================================
// Field positions.
`define CTRL_ENABLE 0
`define CTRL_ARM    1
`define CTRL_BREAK_ENABLE  2
`define CTRL_TAG    3
`define TRIG_BEGIN  4
`define TRIG_LOOP1  5
`define CMP_DIR_EN  16
`define CMP_DIR_SEL 17
// =====================================================================
// Trigger modes, counts and reset values.
`define MODE_A_ONLY    4'h0
`define MODE_A_OR_B    4'h1
`define MODE_A_THEN_B  4'h2
`define MODE_EV_B      4'h3
`define MODE_A_THEN_EV 4'h4
`define MODE_A_AND_B   4'h5
`define MODE_A_NOT_B   4'h6
`define COUNT_FULL     4'h8
`define RST_WORD       32'h0000_0000
`endif

// File: rtl/dbg_trace_pkg.sv
// Types shared by the debug trigger block and its comparator and FIFO.
// Assumes the constants header is compiled alongside.
package dbg_trace_pkg;
   // =====================================================================
   // Run state of the trace controller.
   typedef enum logic [1:0] {RUN_IDLE, RUN_END, RUN_WAIT, RUN_FILL} run_e;
   // Core bus sample; rd high marks a read cycle.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  rdata;
      logic [7:0]  wdata;
      logic        rd;
      logic        valid;
   } core_bus_s;
   // Change-of-flow event from the core.
   typedef struct packed {
      logic [15:0] addr;
      logic        valid;
   } cof_s;
   // One comparator's stored address and direction bits.
   typedef struct packed {
      logic [15:0] addr;
      logic        dir_en;
      logic        dir_sel;
   } cmp_cfg_s;
   // Control and trigger bits.
   typedef struct packed {
      logic       enable;
      logic       arm;
      logic       break_enable;
      logic       tag;
      logic [3:0] mode;
      logic       begin_sel;
      logic       loop1;
   } ctrl_s;
endpackage

// File: rtl/cmp_unit.sv
// One address or data comparator, purely combinational.
// Assumes the caller qualifies full mode and the full-mode direction.
module cmp_unit
   import dbg_trace_pkg::*;
(
   input  wire core_bus_s bus,
   input  wire cmp_cfg_s  cfg,
   input  wire logic      full_mode,
   input  wire logic      full_write,
   input  wire logic      data_mode,
   output logic           match
);
   logic dir_ok;
   logic val_ok;
   logic [7:0] dsel;

   // Direction and value checks; a match needs a live bus cycle.
   always_comb begin
      dsel = full_write ? bus.wdata : bus.rdata;
      if (full_mode) begin
         dir_ok = full_write ? !bus.rd : bus.rd;
      end else begin
         dir_ok = !cfg.dir_en || (bus.rd == cfg.dir_sel);
      end
      val_ok = data_mode ? (dsel == cfg.addr[7:0]) : (bus.addr == cfg.addr);
      match  = bus.valid && dir_ok && val_ok;
   end
endmodule

// File: rtl/trace_fifo.sv
// Eight-entry trace FIFO that overwrites its oldest word when full.
// Assumes push and pop never come in the same cycle as clear.
`include "dbg_trace_map.svh"
module trace_fifo
   import dbg_trace_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        clear,
   input  wire logic        push,
   input  wire logic [15:0] push_data,
   input  wire logic        pop,
   output logic [15:0]      rd_data
);
   typedef struct packed {
      logic [2:0] wp;
      logic [2:0] rp;
      logic [3:0] level;
   } fifo_st_s;
   fifo_st_s st_ff;
   fifo_st_s nxt_st;
   logic [15:0] mem [8];

   // Pointer update; a push into a full buffer drops the oldest word.
   always_comb begin
      nxt_st = st_ff;
      if (clear) begin
         nxt_st = '0;
      end else if (push) begin
         nxt_st.wp = st_ff.wp + 3'h1;
         if (st_ff.level == `COUNT_FULL) begin
            nxt_st.rp = st_ff.rp + 3'h1;
         end else begin
            nxt_st.level = st_ff.level + 4'h1;
         end
      end else if (pop && st_ff.level != 4'h0) begin
         nxt_st.rp    = st_ff.rp + 3'h1;
         nxt_st.level = st_ff.level - 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Storage has no reset; words are only read behind a valid count.
   always_ff @(posedge sys_clk) begin
      if (ce && push && !clear) begin
         mem[st_ff.wp] <= push_data;
      end
   end

   assign rd_data = (st_ff.level == 4'h0) ? 16'h0000 : mem[st_ff.rp];
endmodule

// File: sim/core_model.sv
// Behavioural CPU core: bus cycles, change-of-flow strobes and break counting.
// Assumes callers enter its tasks just after a rising edge of sys_clk.
module core_model
   import dbg_trace_pkg::*;
(
   input  wire logic sys_clk,
   output core_bus_s core_bus,
   output cof_s      change_of_flow,
   input  wire logic brk_force,
   input  wire logic brk_tag
);
   timeunit 1ns;
   timeprecision 1ns;
   int n_force = 0;
   int n_tag   = 0;
   // =====================================================================
   // Break pulses stand one cycle, so each edge with a high level is one request.
   always @(posedge sys_clk) begin
      if (brk_force === 1'b1) n_force++;
      if (brk_tag === 1'b1) n_tag++;
   end
   initial begin
      core_bus = '0;
      change_of_flow      = '0;
   end
   // One bus cycle; idle address, read data and rd are inverted and valid drops, so stale values never match.
   task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic rd);
      core_bus <= '{addr: a, rdata: rd ? d : ~d, wdata: rd ? ~d : d, rd: rd, valid: 1'b1};
      @(posedge sys_clk);
      core_bus <= '{addr: ~a, rdata: ~d, wdata: d, rd: ~rd, valid: 1'b0};
      repeat (3) @(posedge sys_clk);
   endtask
   // One change-of-flow strobe, then quiet cycles for the break to land.
   task automatic cofev(input logic [15:0] a);
      change_of_flow <= '{addr: a, valid: 1'b1};
      @(posedge sys_clk);
      change_of_flow <= '{addr: ~a, valid: 1'b0};
      repeat (3) @(posedge sys_clk);
   endtask
endmodule

// File: sim/tb_dbg_trace.sv
// Self-checking bench for the debug trigger block over its Avalon registers.
// Assumes core_model stands in for the CPU core on the same clock.
`include "dbg_trace_map.svh"
module tb_dbg_trace
   import dbg_trace_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        ce = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic        avs_waitrequest, brk_force, brk_tag, trace_armed;
   core_bus_s   core_bus;
   cof_s        change_of_flow;
   int          fail_count = 0;
   int          n_compared = 0;
   int          nf = 0;
   dbg_trace dbg_trace_i (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_bus(core_bus), .change_of_flow(change_of_flow),
      .brk_force(brk_force), .brk_tag(brk_tag), .trace_armed(trace_armed));
   core_model core_model_i (.sys_clk(sys_clk), .core_bus(core_bus), .change_of_flow(change_of_flow),
      .brk_force(brk_force), .brk_tag(brk_tag));
   // =====================================================================
   // Clock at 100 MHz.
   initial forever #5 sys_clk = ~sys_clk;
   task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", w, e, s);
      end
   endtask
   // Avalon access; the request is held until waitrequest is seen low.
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) fail_count++;
      @(posedge sys_clk);
   endtask
   task automatic rchk(input string w, input logic [4:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(w, q, e);
   endtask
   // Disarm first, since arming is only taken while not armed.
   task automatic arm(input logic [31:0] t, input logic [31:0] c);
      acc(1'b1, `OFS_CTRL, 32'h0);
      acc(1'b1, `OFS_TRIG, t);
      acc(1'b1, `OFS_CTRL, c);
   endtask
   task automatic frc(input string s);
      chk("force", core_model_i.n_force, nf);
      $display("test %s finished", s);
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // =====================================================================
   // Watchdog; the tests need a few hundred cycles.
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      rchk("ctrl", `OFS_CTRL, 32'h0);
      rchk("cmp_c", `OFS_CMP_C, 32'h0);
      frc("reset");
      // Arm without enable: nothing may happen.
      acc(1'b1, `OFS_CMP_A, 32'h0000_1234);
      arm(32'h0, 32'h6);
      core_model_i.cofev(16'h0111);
      core_model_i.cyc(16'h1234, 8'h00, 1'b1);
      rchk("count", `OFS_COUNT, 32'h0);
      frc("disabled");
      // End run: ten captures, oldest two dropped, break at the A match.
      arm(32'h0, 32'h7);
      for (int i = 1; i <= 10; i++) core_model_i.cofev(16'h0100 + 16'(i));
      rchk("count", `OFS_COUNT, 32'h8);
      core_model_i.cyc(16'h1234, 8'h00, 1'b1);
      nf++;
      chk("armed", {31'h0, trace_armed}, 32'h0);
      for (int i = 3; i <= 10; i++) rchk("fifo", `OFS_FIFO, 32'h0100 + i);
      rchk("count", `OFS_COUNT, 32'h8);
      frc("end run");
      // Without break enable the trigger ends the run silently.
      arm(32'h0, 32'h3);
      core_model_i.cyc(16'h1234, 8'h00, 1'b0);
      chk("armed", {31'h0, trace_armed}, 32'h0);
      frc("no break");
      arm(32'h0, 32'hF);
      core_model_i.cyc(16'h1234, 8'h00, 1'b1);
      chk("tag", core_model_i.n_tag, 1);
      frc("tag kind");
      // Begin run: capture starts at the trigger, break at the eighth word.
      arm(32'h10, 32'h7);
      core_model_i.cofev(16'h0300);
      core_model_i.cyc(16'h1234, 8'h00, 1'b1);
      for (int i = 1; i <= 7; i++) core_model_i.cofev(16'h0400 + 16'(i));
      frc("begin partial");
      core_model_i.cofev(16'h0408);
      nf++;
      rchk("count", `OFS_COUNT, 32'h8);
      rchk("fifo", `OFS_FIFO, 32'h0401);
      frc("begin run");
      // Loop1: C cleared on arming, duplicates filtered, no C breakpoint.
      acc(1'b1, `OFS_CMP_C, 32'h0000_00FF);
      arm(32'h20, 32'h7);
      rchk("cmp_c", `OFS_CMP_C, 32'h0);
      for (int i = 0; i < 4; i++) core_model_i.cofev(i < 2 ? 16'h0500 : 16'h0600);
      rchk("count", `OFS_COUNT, 32'h2);
      rchk("cmp_c", `OFS_CMP_C, 32'h0600);
      // A frozen clock enable must let a change of flow pass unseen.
      ce <= 1'b0;
      core_model_i.cofev(16'h0700);
      ce <= 1'b1;
      rchk("count", `OFS_COUNT, 32'h2);
      core_model_i.cyc(16'h0600, 8'h00, 1'b1);
      frc("loop1");
      // Comparator C as a plain breakpoint, no arming needed.
      acc(1'b1, `OFS_CMP_C, 32'h0000_0777);
      arm(32'h0, 32'h5);
      core_model_i.cyc(16'h0777, 8'h00, 1'b1);
      nf++;
      frc("cmp c break");
      // Full mode A and B: write direction from A, B bits say read.
      acc(1'b1, `OFS_CMP_A, 32'h0001_2000);
      acc(1'b1, `OFS_CMP_B, 32'h0003_0055);
      arm(32'h5, 32'h7);
      core_model_i.cyc(16'h2000, 8'h55, 1'b1);
      frc("full read");
      core_model_i.cyc(16'h2000, 8'h55, 1'b0);
      nf++;
      frc("full write");
      print_verdict();
   end
endmodule
